// >>> hw/tmr8_pkg.sv
// package for the 8-bit timer with one compare output channel
// assumes a byte-wide register port on the single 25 MHz clock
package tmr8_pkg;
  // register offsets (byte index on the plain register port)
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
  localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h4;

  // control register field positions
  localparam int CTL_CS_LSB = 0;
  localparam int CTL_WGM1_BIT = 3;
  localparam int CTL_COM_LSB = 4;
  localparam int CTL_WGM0_BIT = 6;
  localparam int CTL_FORCE_BIT = 7;

  // mask / flag bit positions
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_COMPARE = 1;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // prescaler taps
  localparam int PRESCALE_WIDTH = 10;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PC_PWM = 2'h1,
    WAVE_CTC = 2'h2,
    WAVE_FAST_PWM = 2'h3
  } tmr8_wave_type;

  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_DIV1 = 3'h1,
    CLK_DIV8 = 3'h2,
    CLK_DIV64 = 3'h3,
    CLK_DIV256 = 3'h4,
    CLK_DIV1024 = 3'h5,
    CLK_EXT_FALL = 3'h6,
    CLK_EXT_RISE = 3'h7
  } tmr8_clksel_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr8_bus_type;

  typedef struct packed {
    logic compare_irq;
    logic overflow_irq;
  } tmr8_irq_type;

  typedef struct packed {
    logic wave_mode1;
    logic wave_mode0;
    logic [1:0] compare_output_mode;
    logic [2:0] clock_select_field;
    logic [7:0] count_value_reg;
    logic [7:0] compare_value_reg;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic compare_match_flag;
    logic overflow_flag;
    logic count_down;
    logic block_match;
    logic compare_wave_out;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic [7:0] rdata;
  } tmr8_state_type;
endpackage

// >>> hw/tmr8_timer.sv
// 8-bit timer/counter with one compare output channel and its registers
// assumes a core-side register port and a global interrupt enable on mclk
// Function
// R1: nonzero output mode hands pin to waveform
// R2: software sets pin direction to output
// R3: non-PWM modes: disconnect, toggle, clear, set
// R4: fast PWM: clear/set on match, opposite at bottom
// R5: phase correct: clear up, set down
// R6: compare equals top: act at top instead
// R7: clock select: stop, div 1/8/64/256/1024
// R8: selects 6/7 count external falling/rising edges
// R9: external edges count even when pin drives
// R10: counter register is readable and writable
// R11: counter write blocks match on next tick
// R12: compare every cycle, set flag, drive wave; here the compare acts only on counter ticks
// R13: compare irq needs enable, global, flag
// R14: overflow irq needs enable, global, flag
// R15: clock select in control bits 2:0
// R16: flags cleared by vector ack or one-write
// R17: waveform mode selects normal/pc/ctc/fast, top
// R18: external edge reaches counter within 2.5-3.5 cycles; here 2 to 3 cycles after the pin edge
// R19: phase correct overflow at bottom reversal
// R20: interrupt requests are level signals
`timescale 1ns/10ps
module tmr8_timer (
  input wire logic mclk, // 25 MHz clock
  input wire logic srst, // synchronous reset, high
  input wire tmr8_pkg::tmr8_bus_type bus, // register port request
  output logic [7:0] rdata, // read data, cycle after read strobe
  input wire logic global_irq_enable, // core global interrupt enable
  input wire logic compare_vector_ack, // compare vector being executed
  input wire logic overflow_vector_ack, // overflow vector being executed
  input wire logic external_count_pin, // asynchronous counter input pin
  output logic compare_wave_out, // waveform value
  output logic compare_wave_override, // waveform owns the pin
  output tmr8_pkg::tmr8_irq_type irq // level interrupt requests
);
  tmr8_pkg::tmr8_state_type s_q;
  tmr8_pkg::tmr8_state_type s_d;
  tmr8_pkg::tmr8_wave_type wave;
  logic tick;
  logic ext_edge;
  logic [7:0] top;
  logic match;
  logic top_special;
  logic at_top;
  logic ovf_evt;
  logic cmp_evt;
  logic wr_ctl;
  logic force_match;

  ////////////////////////////////////////////////////////////////////////
  // clock source and compare logic
  always_comb begin
    wave = tmr8_pkg::tmr8_wave_type'({s_q.wave_mode1, s_q.wave_mode0}); // see R17
    top = (wave == tmr8_pkg::WAVE_CTC) ? s_q.compare_value_reg : tmr8_pkg::COUNT_MAX; // see R17
    // edge taken from the second and third stage, never the first
    ext_edge = (s_q.clock_select_field == tmr8_pkg::CLK_EXT_RISE) ? (s_q.ext_sync2 & ~s_q.ext_prev)
                                                                   : (~s_q.ext_sync2 & s_q.ext_prev); // see R8 R9 R18
    tick = 1'b0;
    unique case (tmr8_pkg::tmr8_clksel_type'(s_q.clock_select_field)) // see R7 R15
      tmr8_pkg::CLK_STOP: tick = 1'b0;
      tmr8_pkg::CLK_DIV1: tick = 1'b1;
      tmr8_pkg::CLK_DIV8: tick = (s_q.prescale[2:0] == tmr8_pkg::TAP_DIV8[2:0]);
      tmr8_pkg::CLK_DIV64: tick = (s_q.prescale[5:0] == tmr8_pkg::TAP_DIV64[5:0]);
      tmr8_pkg::CLK_DIV256: tick = (s_q.prescale[7:0] == tmr8_pkg::TAP_DIV256[7:0]);
      tmr8_pkg::CLK_DIV1024: tick = (s_q.prescale == tmr8_pkg::TAP_DIV1024);
      tmr8_pkg::CLK_EXT_FALL, tmr8_pkg::CLK_EXT_RISE: tick = ext_edge;
    endcase
    // compare acts only on counter ticks; blocked on the tick after a counter write
    match = (s_q.count_value_reg == s_q.compare_value_reg) && tick && !s_q.block_match; // see R12 R11
    top_special = (s_q.compare_value_reg == top) && s_q.compare_output_mode[1]
                  && (wave == tmr8_pkg::WAVE_PC_PWM || wave == tmr8_pkg::WAVE_FAST_PWM); // see R6
    at_top = tick && (s_q.count_value_reg == top);
    wr_ctl = bus.wr && (bus.addr == tmr8_pkg::ADDR_CONTROL);
    // forced compare only in non-PWM modes, changes wave but raises no flag
    force_match = wr_ctl && bus.wdata[tmr8_pkg::CTL_FORCE_BIT] && !bus.wdata[tmr8_pkg::CTL_WGM0_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    ovf_evt = 1'b0;
    cmp_evt = match;
    s_d.prescale = s_q.prescale + 10'h001;
    s_d.ext_sync1 = external_count_pin; // see R9
    s_d.ext_sync2 = s_q.ext_sync1;
    s_d.ext_prev = s_q.ext_sync2;
    if (tick) begin
      s_d.block_match = 1'b0;
    end

    // counter
    if (tick) begin
      unique case (wave)
        tmr8_pkg::WAVE_PC_PWM: begin
          if (!s_q.count_down) begin
            if (s_q.count_value_reg == tmr8_pkg::COUNT_MAX) begin
              s_d.count_down = 1'b1;
              s_d.count_value_reg = s_q.count_value_reg - 8'h01;
            end else begin
              s_d.count_value_reg = s_q.count_value_reg + 8'h01;
            end
          end else if (s_q.count_value_reg == tmr8_pkg::COUNT_BOTTOM) begin
            s_d.count_down = 1'b0;
            s_d.count_value_reg = s_q.count_value_reg + 8'h01;
            ovf_evt = 1'b1; // see R19
          end else begin
            s_d.count_value_reg = s_q.count_value_reg - 8'h01;
          end
        end
        tmr8_pkg::WAVE_CTC: begin
          s_d.count_down = 1'b0;
          if (s_q.count_value_reg == top) begin
            s_d.count_value_reg = tmr8_pkg::COUNT_BOTTOM;
          end else begin
            s_d.count_value_reg = s_q.count_value_reg + 8'h01;
          end
          ovf_evt = (s_q.count_value_reg == tmr8_pkg::COUNT_MAX);
        end
        default: begin
          s_d.count_down = 1'b0;
          s_d.count_value_reg = s_q.count_value_reg + 8'h01;
          ovf_evt = (s_q.count_value_reg == tmr8_pkg::COUNT_MAX);
        end
      endcase
    end

    // waveform
    unique case (wave)
      tmr8_pkg::WAVE_NORMAL, tmr8_pkg::WAVE_CTC: begin
        if (match || force_match) begin
          unique case (s_q.compare_output_mode) // see R3
            2'h0: s_d.compare_wave_out = s_q.compare_wave_out;
            2'h1: s_d.compare_wave_out = ~s_q.compare_wave_out;
            2'h2: s_d.compare_wave_out = 1'b0;
            2'h3: s_d.compare_wave_out = 1'b1;
          endcase
        end
      end
      tmr8_pkg::WAVE_FAST_PWM: begin
        if (s_q.compare_output_mode[1]) begin // see R4
          if (top_special) begin
            if (at_top) begin
              s_d.compare_wave_out = s_q.compare_output_mode[0]; // see R6
            end
          end else if (match) begin
            s_d.compare_wave_out = s_q.compare_output_mode[0];
          end else if (at_top) begin
            s_d.compare_wave_out = ~s_q.compare_output_mode[0];
          end
        end
      end
      tmr8_pkg::WAVE_PC_PWM: begin
        if (s_q.compare_output_mode[1]) begin // see R5
          if (top_special) begin
            if (at_top) begin
              s_d.compare_wave_out = s_q.compare_output_mode[0]; // see R6
            end
          end else if (match) begin
            s_d.compare_wave_out = s_q.count_down ^ s_q.compare_output_mode[0];
          end
        end
      end
    endcase

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        tmr8_pkg::ADDR_CONTROL: begin
          s_d.wave_mode0 = bus.wdata[tmr8_pkg::CTL_WGM0_BIT];
          s_d.wave_mode1 = bus.wdata[tmr8_pkg::CTL_WGM1_BIT];
          s_d.compare_output_mode = bus.wdata[tmr8_pkg::CTL_COM_LSB +: 2];
          s_d.clock_select_field = bus.wdata[tmr8_pkg::CTL_CS_LSB +: 3]; // see R15
        end
        tmr8_pkg::ADDR_COUNT: begin
          s_d.count_value_reg = bus.wdata; // see R10
          s_d.block_match = 1'b1; // see R11
        end
        tmr8_pkg::ADDR_COMPARE: s_d.compare_value_reg = bus.wdata;
        tmr8_pkg::ADDR_IRQ_MASK: begin
          s_d.compare_irq_enable = bus.wdata[tmr8_pkg::BIT_COMPARE];
          s_d.overflow_irq_enable = bus.wdata[tmr8_pkg::BIT_OVERFLOW];
        end
        default: ;
      endcase
    end

    // flags: clear by one-write or vector ack, a new event wins
    if ((bus.wr && bus.addr == tmr8_pkg::ADDR_IRQ_FLAGS && bus.wdata[tmr8_pkg::BIT_COMPARE])
        || compare_vector_ack) begin
      s_d.compare_match_flag = 1'b0; // see R16
    end
    if ((bus.wr && bus.addr == tmr8_pkg::ADDR_IRQ_FLAGS && bus.wdata[tmr8_pkg::BIT_OVERFLOW])
        || overflow_vector_ack) begin
      s_d.overflow_flag = 1'b0; // see R16
    end
    if (cmp_evt) begin
      s_d.compare_match_flag = 1'b1; // see R12
    end
    if (ovf_evt) begin
      s_d.overflow_flag = 1'b1;
    end

    // read data, valid only in the cycle after the strobe
    s_d.rdata = tmr8_pkg::RESET_BYTE;
    if (bus.rd) begin
      unique case (bus.addr)
        tmr8_pkg::ADDR_CONTROL: s_d.rdata = {1'b0, s_q.wave_mode0, s_q.compare_output_mode,
                                             s_q.wave_mode1, s_q.clock_select_field};
        tmr8_pkg::ADDR_COUNT: s_d.rdata = s_q.count_value_reg; // see R10
        tmr8_pkg::ADDR_COMPARE: s_d.rdata = s_q.compare_value_reg;
        tmr8_pkg::ADDR_IRQ_MASK: s_d.rdata = {6'h00, s_q.compare_irq_enable, s_q.overflow_irq_enable};
        tmr8_pkg::ADDR_IRQ_FLAGS: s_d.rdata = {6'h00, s_q.compare_match_flag, s_q.overflow_flag};
        default: s_d.rdata = tmr8_pkg::RESET_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; pin direction stays with software, see R2
  assign rdata = s_q.rdata;
  assign compare_wave_out = s_q.compare_wave_out;
  assign compare_wave_override = |s_q.compare_output_mode; // see R1
  assign irq.compare_irq = s_q.compare_irq_enable && global_irq_enable && s_q.compare_match_flag; // see R13 R20
  assign irq.overflow_irq = s_q.overflow_irq_enable && global_irq_enable && s_q.overflow_flag; // see R14 R20
endmodule

// >>> dv/tmr8_timer_assertions.sv
// checker for the timer register port and interrupt outputs
// assumes binding onto the timer top, single clock
`timescale 1ns/10ps
module tmr8_timer_chk (
  input wire logic mclk, // clock
  input wire logic srst, // reset
  input wire tmr8_pkg::tmr8_bus_type bus, // request
  input wire logic [7:0] rdata, // read data
  input wire logic global_irq_enable, // global enable
  input wire logic compare_vector_ack, // vector ack
  input wire logic compare_wave_out, // wave
  input wire logic compare_wave_override, // pin owner
  input wire tmr8_pkg::tmr8_irq_type irq // requests
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_override_follow: assert property (
    bus.wr && bus.addr == tmr8_pkg::ADDR_CONTROL |=> compare_wave_override == |$past(bus.wdata[5:4]))
    else $error("override not following mode bits");
  a_read_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_read: assert property (
    bus.rd && bus.addr > tmr8_pkg::ADDR_IRQ_FLAGS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    (bus.wr && bus.addr == 3'h0) ##1 (bus.rd && bus.addr == 3'h0) |=> rdata == {1'b0, $past(bus.wdata[6:0], 2)})
    else $error("control readback wrong");
  a_mask_readback: assert property (
    (bus.wr && bus.addr == 3'h3) ##1 (bus.rd && bus.addr == 3'h3) |=> rdata[1:0] == $past(bus.wdata[1:0], 2))
    else $error("mask readback wrong");
  a_cmp_gate: assert property (!global_irq_enable |-> !irq.compare_irq)
    else $error("compare request without global enable");
  a_ovf_gate: assert property (!global_irq_enable |-> !irq.overflow_irq)
    else $error("overflow request without global enable");
  a_cmp_level: assert property (
    irq.compare_irq && !compare_vector_ack && !(bus.wr && bus.addr >= 3'h3) |=> irq.compare_irq || !global_irq_enable)
    else $error("compare request dropped");
  c_irq: cover property (irq.compare_irq);
  c_wave: cover property (compare_wave_override && compare_wave_out);
  c_read: cover property (bus.rd ##1 rdata != 8'h00);
endmodule
bind tmr8_timer tmr8_timer_chk u_chk (.mclk, .srst, .bus, .rdata, .global_irq_enable, .compare_vector_ack,
  .compare_wave_out, .compare_wave_override, .irq);

// >>> dv/tmr8_core_model.sv
// core side model: takes vectors for pending requests, owns pin direction
// assumes level requests from the timer
`timescale 1ns/10ps
module tmr8_core_model (
  input wire logic mclk, // clock
  input wire logic srst, // reset
  input wire tmr8_pkg::tmr8_irq_type irq, // requests
  input wire logic wave, // waveform value
  input wire logic override, // waveform owns pin
  input wire logic dir_out, // pin direction bit
  output logic compare_vector_ack = 1'b0, // vector taken
  output logic overflow_vector_ack = 1'b0, // vector taken
  output logic pin // pin level, pulled up when undriven
);
  // compare wins, one pulse per request so a flag is never acked twice
  always_ff @(posedge mclk) begin
    compare_vector_ack <= !srst && irq.compare_irq && !compare_vector_ack;
    overflow_vector_ack <= !srst && irq.overflow_irq && !overflow_vector_ack && !irq.compare_irq;
  end
  assign pin = (override && dir_out) ? wave : 1'b1;
endmodule

// >>> dv/tmr8_testbench.sv
// self-checking bench for the 8-bit timer
// assumes the core model and bound checker are compiled alongside
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic [7:0] ctl; logic [7:0] cv; logic [7:0] st; logic [11:0] cyc; logic wv;} tmr8_run_type;
  localparam tmr8_run_type RUNS [10] = '{'{8'h31, 8'h10, 8'h0E, 12'h008, 1'b1}, '{8'h29, 8'h10, 8'h0E, 12'h008, 1'b0},
    '{8'h11, 8'h10, 8'h0E, 12'h008, 1'b1}, '{8'h19, 8'h10, 8'h0E, 12'h008, 1'b0},
    '{8'h69, 8'h80, 8'hF0, 12'h050, 1'b1}, '{8'h69, 8'h80, 8'hF0, 12'h0A0, 1'b0},
    '{8'h79, 8'h80, 8'hF0, 12'h050, 1'b0}, '{8'h61, 8'h80, 8'h10, 12'h0C0, 1'b0},
    '{8'h71, 8'h80, 8'h10, 12'h0C0, 1'b1}, '{8'h61, 8'h80, 8'h10, 12'h1B0, 1'b1}};
  localparam int DIV [6] = '{1, 1, 8, 64, 256, 1024};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  tmr8_pkg::tmr8_bus_type bus = '0;
  logic gie = 1'b0;
  logic ext_pin = 1'b0;
  logic [7:0] rdata;
  logic wave, ovr, cack, oack, pin;
  tmr8_pkg::tmr8_irq_type irq;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] rnd;
  int fails = 0;
  int checks = 0;
  always #20 mclk = ~mclk;
  tmr8_timer dut (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata), .global_irq_enable(gie),
    .compare_vector_ack(cack), .overflow_vector_ack(oack), .external_count_pin(ext_pin),
    .compare_wave_out(wave), .compare_wave_override(ovr), .irq(irq));
  tmr8_core_model core (.mclk(mclk), .srst(srst), .irq(irq), .wave(wave), .override(ovr), .dir_out(1'b1),
    .compare_vector_ack(cack), .overflow_vector_ack(oack), .pin(pin));
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
  endtask
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge mclk);
  endtask
  // stop, load, run a fixed number of ticks, stop again, then look at the pin
  task automatic run(input tmr8_run_type r);
    wr(3'h0, r.ctl & 8'h78);
    wr(3'h2, r.cv);
    wr(3'h1, r.st);
    wr(3'h0, r.ctl);
    idle(r.cyc);
    wr(3'h0, r.ctl & 8'h78);
    idle(2);
    cmp("wave", {7'h00, r.wv}, {7'h00, wave});
    cmp("override", 8'h01, {7'h00, ovr});
    cmp("pin", {7'h00, r.wv}, {7'h00, pin});
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_seen <= bus.rd;
    if (rd_seen) cmp("rdata", exp_q.size() ? exp_q.pop_front() : 8'h5A, rdata);
  end
  task automatic finish_test();
    if (exp_q.size() != 0) fails++;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    finish_test();
  end
  initial begin
    rnd = $urandom(32'hC3115913);
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    for (int n = 0; n < 8; n++) rd(n[2:0], tmr8_pkg::RESET_BYTE);
    rnd = $urandom();
    wr(3'h0, {1'b1, rnd[6:3], 3'h0});
    rd(3'h0, {1'b0, rnd[6:3], 3'h0});
    wr(3'h1, rnd);
    rd(3'h1, rnd);
    wr(3'h2, ~rnd);
    rd(3'h2, ~rnd);
    wr(3'h3, {6'h00, rnd[1:0]});
    rd(3'h3, {6'h00, rnd[1:0]});
    wr(3'h5, rnd);
    rd(3'h5, 8'h00);
    $display("test registers done");
    for (int n = 0; n < 6; n++) begin
      wr(3'h1, 8'h00);
      wr(3'h0, n[7:0]);
      idle(n == 0 ? 3 : 4 * DIV[n] - 1);
      wr(3'h0, 8'h00);
      rd(3'h1, n == 0 ? 8'h00 : 8'h04);
    end
    for (int n = 6; n < 8; n++) begin
      wr(3'h1, 8'h00);
      wr(3'h0, n[7:0]);
      repeat (3) begin
        ext_pin <= 1'b1;
        idle($urandom_range(4, 2));
        ext_pin <= 1'b0;
        idle($urandom_range(4, 2));
      end
      idle(5);
      wr(3'h0, 8'h00);
      rd(3'h1, 8'h03);
    end
    $display("test clock select done");
    for (int n = 0; n < 10; n++) run(RUNS[n]);
    $display("test waveform done");
    wr(3'h3, 8'h03);
    wr(3'h4, 8'hFF);
    run('{8'h31, 8'h10, 8'hFE, 12'h016, 1'b1});
    rd(3'h4, 8'h03);
    cmp("irq", 8'h00, {6'h00, irq});
    wr(3'h4, 8'h01);
    rd(3'h4, 8'h02);
    gie <= 1'b1;
    idle(1);
    cmp("irq", 8'h02, {6'h00, irq});
    idle(4);
    rd(3'h4, 8'h00);
    // overflow request alone, cleared by its vector
    gie <= 1'b0;
    run('{8'h31, 8'h10, 8'hFE, 12'h016, 1'b1});
    wr(3'h4, 8'h02);
    gie <= 1'b1;
    idle(1);
    cmp("irq", 8'h01, {6'h00, irq});
    idle(4);
    rd(3'h4, 8'h00);
    wr(3'h0, 8'h00);
    idle(2);
    cmp("override", 8'h00, {7'h00, ovr});
    cmp("pin", 8'h01, {7'h00, pin});
    $display("test interrupts done");
    idle(3);
    finish_test();
  end
endmodule
